// ---- sld_led_panel.sv ----
/*
 * Front-panel model: the eleven indicators as an operator sees them.
 * Assumes 3-bit colour codes, LED 1 in the low bits of ledCodes.
 */
`timescale 1ns/10ps
`default_nettype none

module sld_led_panel (
	// Indicator colour codes
	input wire logic [32:0] ledCodes,
	// Operator view
	output logic [3:0] litCount,
	output logic badCode
);
	// ------
	// A code with no LED colour behind it shows as a fault
	// ------
	always_comb begin
		litCount = 4'h0;
		badCode = 1'h0;
		for (int i = 0; i < 11; i++) begin
			if (ledCodes[3*i+:3] != 3'h0) litCount = litCount + 4'h1;
			if (ledCodes[3*i+:3] > 3'h5) badCode = 1'h1;
		end
	end
endmodule

`default_nettype wire

// ---- sld_pkg.sv ----
/*
 * Constants shared by the scanner status indicator driver: colour codes,
 * register offsets and fields, reset values and blink timing.
 * Assumes a single 40 MHz system clock.
 */
`default_nettype none

package sld_pkg;

	// ----------------------------------------------------------------
	// Indicator colour codes (one code per LED drive port)
	// ----------------------------------------------------------------
	localparam logic [2:0] SLD_COL_OFF = 3'h0;
	localparam logic [2:0] SLD_COL_RED = 3'h1;
	localparam logic [2:0] SLD_COL_GREEN = 3'h2;
	localparam logic [2:0] SLD_COL_YELLOW = 3'h3;
	localparam logic [2:0] SLD_COL_BLUE = 3'h4;
	localparam logic [2:0] SLD_COL_ORANGE = 3'h5;
	localparam int SLD_COL_W = 3;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int SLD_ADDR_W = 8;
	localparam int SLD_DATA_W = 32;
	localparam logic [7:0] SLD_REG_CTRL = 8'h00;
	localparam logic [7:0] SLD_REG_STAT0 = 8'h04;
	localparam logic [7:0] SLD_REG_STAT1 = 8'h08;
	localparam logic [7:0] SLD_REG_PHASE = 8'h0C;
	localparam int SLD_CTRL_FOURFIELD_BIT = 0;
	localparam logic SLD_CTRL_FOURFIELD_RST = 1'h0;
	localparam logic [31:0] SLD_RD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Blink timebase
	// ----------------------------------------------------------------
	localparam int unsigned SLD_CLK_HZ = 40_000_000;
	localparam int unsigned SLD_BLINK_HALF_MS = 250;
	localparam int unsigned SLD_BLINK_HALF_CYC = SLD_CLK_HZ / 1000 * SLD_BLINK_HALF_MS;
	localparam int SLD_BLINK_CNT_W = 24;
	localparam logic [23:0] SLD_BLINK_CNT_RST = 24'h00_0000;
	localparam logic SLD_BLINK_PHASE_RST = 1'h0;

endpackage

`default_nettype wire

// ---- sld_status_led_driver.sv ----
/*
 * Status indicator driver for the safety laser scanner front panel.
 * Maps internal device state onto eleven colour-coded indicators,
 * steady or flashing, from one shared blink timebase.
 * Assumes all status inputs are synchronous to core_clk and that the
 * register master follows the one-cycle strobe protocol.
 */
// Functional notes
// - Indicator 2 dark: interlock disabled or released
// - Indicator 2 yellow ready, flashing when field occupied
// - Four-field: indicator 4 dark, field 3 free
// - Four-field: indicator 4 blue, field 3 interrupted
// - Four-field: indicator 5 flashes yellow, field 2
// - Power red on self-test or comm fault
// - Power green; flashes green during identification blink
// - Safety comm: dark idle, red flash/steady errors
// - Safety comm flashes green: passive or identification
// - Safety comm steady green while protocol active
// - Network dark idle; orange flash on topology error
// - Network flashes green: initialising or identification
// - Network steady green during cyclic data exchange
// - Network flashes red: config fail, no/invalid data
// - Network steady red on bus error
// - Port indicator dark without link
// - Port indicator green: link, no traffic
// - Port indicator green/orange alternating during traffic
`timescale 1ns/10ps
`default_nettype none

module sld_status_led_driver #(
	parameter int unsigned BLINK_HALF_CYC = sld_pkg::SLD_BLINK_HALF_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Safety output and restart interlock state
	input wire logic safetySwitchingOutputOn,
	input wire logic deviceError,
	input wire logic restartInterlockEnabled,
	input wire logic restartInterlockReleased,
	input wire logic protFieldOccupied,
	input wire logic linkedSensorEnabled,
	// Warning fields
	input wire logic warnFieldInterrupted,
	input wire logic warnField2Interrupted,
	input wire logic warnField3Interrupted,
	// Device health and identification blink
	input wire logic selfTestFail,
	input wire logic internalCommError,
	input wire logic identBlinkActive,
	// Safety protocol state
	input wire logic safetyCommOn,
	input wire logic safetyCommPassive,
	input wire logic safetyCommActive,
	input wire logic safetyConfigFail,
	input wire logic safetyCommError,
	// Fieldbus state
	input wire logic busInitialising,
	input wire logic busDataExchange,
	input wire logic topologyError,
	input wire logic netConfigFail,
	input wire logic noDataExchange,
	input wire logic invalidData,
	input wire logic busError,
	// Ethernet ports
	input wire logic port1Link,
	input wire logic port1Activity,
	input wire logic port2Link,
	input wire logic port2Activity,
	// Register port
	input wire logic [sld_pkg::SLD_ADDR_W-1:0] regAddr,
	input wire logic [sld_pkg::SLD_DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [sld_pkg::SLD_DATA_W-1:0] regRdData,
	// Indicator colour drives
	output logic [sld_pkg::SLD_COL_W-1:0] safetyOutputIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] restartIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] warnFieldIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] warnField3Indicator,
	output logic [sld_pkg::SLD_COL_W-1:0] warnField2Indicator,
	output logic [sld_pkg::SLD_COL_W-1:0] spareIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] powerIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] safetyCommIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] networkIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] port1LinkActivityIndicator,
	output logic [sld_pkg::SLD_COL_W-1:0] port2LinkActivityIndicator
);
	import sld_pkg::*;

	// ----------------------------------------------------------------
	// Blink timebase
	// ----------------------------------------------------------------
	logic [SLD_BLINK_CNT_W-1:0] blinkCnt_q;
	logic blinkPhase_q;
	logic blinkTick;

	assign blinkTick = (blinkCnt_q == SLD_BLINK_CNT_W'(BLINK_HALF_CYC - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blinkCnt_q <= SLD_BLINK_CNT_RST;
		end else if (blinkTick) begin
			blinkCnt_q <= SLD_BLINK_CNT_RST;
		end else begin
			blinkCnt_q <= blinkCnt_q + SLD_BLINK_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blinkPhase_q <= SLD_BLINK_PHASE_RST;
		end else if (blinkTick) begin
			blinkPhase_q <= ~blinkPhase_q;
		end
	end

	// Flashing colour: lit in the high half of the shared phase
	function automatic logic [2:0] flash(input logic [2:0] col, input logic phase);
		flash = phase ? col : SLD_COL_OFF;
	endfunction

	// Link/activity colour for one Ethernet port
	function automatic logic [2:0] portColour(input logic link, input logic act,
		input logic phase);
		if (!link) begin
			portColour = SLD_COL_OFF;
		end else if (act) begin
			portColour = phase ? SLD_COL_GREEN : SLD_COL_ORANGE;
		end else begin
			portColour = SLD_COL_GREEN;
		end
	endfunction

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic fourFieldMode_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fourFieldMode_q <= SLD_CTRL_FOURFIELD_RST;
		end else if (regWr && regAddr == SLD_REG_CTRL) begin
			fourFieldMode_q <= regWrData[SLD_CTRL_FOURFIELD_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Indicator decode
	// ----------------------------------------------------------------
	logic [2:0] safetyOutD;
	logic [2:0] restartD;
	logic [2:0] warnD;
	logic [2:0] warn3D;
	logic [2:0] warn2D;
	logic [2:0] powerD;
	logic [2:0] safetyCommD;
	logic [2:0] networkD;

	always_comb begin
		if (deviceError) begin
			safetyOutD = flash(SLD_COL_RED, blinkPhase_q);
		end else if (safetySwitchingOutputOn) begin
			safetyOutD = SLD_COL_GREEN;
		end else begin
			safetyOutD = SLD_COL_RED;
		end
	end

	always_comb begin
		if (!restartInterlockEnabled || restartInterlockReleased) begin
			restartD = SLD_COL_OFF;
		end else if (protFieldOccupied) begin
			restartD = flash(SLD_COL_YELLOW, blinkPhase_q);
		end else if (linkedSensorEnabled) begin
			restartD = SLD_COL_YELLOW;
		end else begin
			restartD = SLD_COL_OFF;
		end
	end

	always_comb begin
		warnD = warnFieldInterrupted ? SLD_COL_BLUE : SLD_COL_OFF;
		warn3D = SLD_COL_OFF;
		warn2D = SLD_COL_OFF;
		if (fourFieldMode_q && warnField3Interrupted) begin
			warn3D = SLD_COL_BLUE;
		end
		if (fourFieldMode_q && warnField2Interrupted) begin
			warn2D = flash(SLD_COL_YELLOW, blinkPhase_q);
		end
	end

	always_comb begin
		if (selfTestFail || internalCommError) begin
			powerD = SLD_COL_RED;
		end else if (identBlinkActive) begin
			powerD = flash(SLD_COL_GREEN, blinkPhase_q);
		end else begin
			powerD = SLD_COL_GREEN;
		end
	end

	always_comb begin
		if (safetyCommError) begin
			safetyCommD = SLD_COL_RED;
		end else if (safetyConfigFail) begin
			safetyCommD = flash(SLD_COL_RED, blinkPhase_q);
		end else if (safetyCommPassive || identBlinkActive) begin
			safetyCommD = flash(SLD_COL_GREEN, blinkPhase_q);
		end else if (safetyCommOn && safetyCommActive) begin
			safetyCommD = SLD_COL_GREEN;
		end else begin
			safetyCommD = SLD_COL_OFF;
		end
	end

	always_comb begin
		if (busError) begin
			networkD = SLD_COL_RED;
		end else if (netConfigFail || noDataExchange || invalidData) begin
			networkD = flash(SLD_COL_RED, blinkPhase_q);
		end else if (topologyError) begin
			networkD = flash(SLD_COL_ORANGE, blinkPhase_q);
		end else if (busInitialising || identBlinkActive) begin
			networkD = flash(SLD_COL_GREEN, blinkPhase_q);
		end else if (busDataExchange) begin
			networkD = SLD_COL_GREEN;
		end else begin
			networkD = SLD_COL_OFF;
		end
	end

	// ----------------------------------------------------------------
	// Indicator drive flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			safetyOutputIndicator <= SLD_COL_OFF;
			restartIndicator <= SLD_COL_OFF;
			warnFieldIndicator <= SLD_COL_OFF;
			warnField3Indicator <= SLD_COL_OFF;
			warnField2Indicator <= SLD_COL_OFF;
			spareIndicator <= SLD_COL_OFF;
			powerIndicator <= SLD_COL_OFF;
			safetyCommIndicator <= SLD_COL_OFF;
			networkIndicator <= SLD_COL_OFF;
		end else begin
			safetyOutputIndicator <= safetyOutD;
			restartIndicator <= restartD;
			warnFieldIndicator <= warnD;
			warnField3Indicator <= warn3D;
			warnField2Indicator <= warn2D;
			spareIndicator <= SLD_COL_OFF;
			powerIndicator <= powerD;
			safetyCommIndicator <= safetyCommD;
			networkIndicator <= networkD;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1LinkActivityIndicator <= SLD_COL_OFF;
			port2LinkActivityIndicator <= SLD_COL_OFF;
		end else begin
			port1LinkActivityIndicator <= portColour(port1Link, port1Activity, blinkPhase_q);
			port2LinkActivityIndicator <= portColour(port2Link, port2Activity, blinkPhase_q);
		end
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	logic [31:0] rdMux;

	always_comb begin
		case (regAddr)
			SLD_REG_CTRL: rdMux = {31'h0000_0000, fourFieldMode_q};
			SLD_REG_STAT0: rdMux = {8'h00, safetyCommIndicator, powerIndicator,
				spareIndicator, warnField2Indicator, warnField3Indicator,
				warnFieldIndicator, restartIndicator, safetyOutputIndicator};
			SLD_REG_STAT1: rdMux = {23'h00_0000, port2LinkActivityIndicator,
				port1LinkActivityIndicator, networkIndicator};
			SLD_REG_PHASE: rdMux = {31'h0000_0000, blinkPhase_q};
			default: rdMux = SLD_RD_ZERO;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= SLD_RD_ZERO;
		end else if (regRd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= SLD_RD_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	safety_out_a: assert property (
		!deviceError && safetySwitchingOutputOn |=> safetyOutputIndicator == SLD_COL_GREEN
	) else $error("indicator 1 not green with output on");

	safety_err_a: assert property (
		deviceError |=> safetyOutputIndicator ==
			($past(blinkPhase_q) ? SLD_COL_RED : SLD_COL_OFF)
	) else $error("indicator 1 not flashing red on error");

	restart_dark_a: assert property (
		(!restartInterlockEnabled || restartInterlockReleased) |=> restartIndicator == SLD_COL_OFF
	) else $error("indicator 2 lit while interlock inactive");

	restart_ready_a: assert property (
		restartInterlockEnabled && !restartInterlockReleased && !protFieldOccupied
			&& linkedSensorEnabled |=> restartIndicator == SLD_COL_YELLOW
	) else $error("indicator 2 not steady yellow when ready");

	spare_dark_a: assert property (
		spareIndicator == SLD_COL_OFF
	) else $error("indicator 6 lit");

	four_field3_a: assert property (
		##1 warnField3Indicator == (($past(fourFieldMode_q) && $past(warnField3Interrupted))
			? SLD_COL_BLUE : SLD_COL_OFF)
	) else $error("indicator 4 wrong for warning field 3");

	four_field2_a: assert property (
		fourFieldMode_q && warnField2Interrupted && blinkPhase_q
			|=> warnField2Indicator == SLD_COL_YELLOW
	) else $error("indicator 5 not yellow in lit phase");

	power_fault_a: assert property (
		(selfTestFail || internalCommError) |=> powerIndicator == SLD_COL_RED
	) else $error("power indicator not red on fault");

	power_ident_a: assert property (
		!selfTestFail && !internalCommError && identBlinkActive && !blinkPhase_q
			|=> powerIndicator == SLD_COL_OFF
	) else $error("power indicator not dark in dark phase");

	safety_comm_a: assert property (
		safetyCommError |=> safetyCommIndicator == SLD_COL_RED
	) else $error("safety comm indicator not red on error");

	net_bus_err_a: assert property (
		busError |=> networkIndicator == SLD_COL_RED
	) else $error("network indicator not red on bus error");

	net_exchange_a: assert property (
		!busError && !netConfigFail && !noDataExchange && !invalidData && !topologyError
			&& !busInitialising && !identBlinkActive && busDataExchange
			|=> networkIndicator == SLD_COL_GREEN
	) else $error("network indicator not green in data exchange");

	port_nolink_a: assert property (
		!port1Link |=> port1LinkActivityIndicator == SLD_COL_OFF
	) else $error("port 1 indicator lit without link");

	port_traffic_a: assert property (
		port2Link && port2Activity && !blinkPhase_q
			|=> port2LinkActivityIndicator == SLD_COL_ORANGE
	) else $error("port 2 indicator not orange in second phase");

	blink_base_a: assert property (
		$changed(blinkPhase_q) |-> $past(blinkTick)
	) else $error("blink phase moved without divider tick");

endmodule

`default_nettype wire

// ---- sld_status_led_driver_test.sv ----
/*
 * Self-checking bench for the status indicator driver: random status and
 * register traffic, checked against a behavioural model every cycle.
 * Assumes sld_pkg, sld_status_led_driver and sld_led_panel are compiled.
 */
`timescale 1ns/10ps
`default_nettype none

module sld_status_led_driver_test;
	import sld_pkg::*;
	localparam int HALF = 4;
	localparam logic [27:0] MASK = 28'hF06_79FD;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [27:0] st = 28'h0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	wire logic [31:0] regRdData;
	wire logic [32:0] outs;
	wire logic [3:0] litCount;
	wire logic badCode;
	logic [31:0] r = 32'h42;
	logic [32:0] expC;
	logic [31:0] expR;
	logic [31:0] expQ[$];
	int lit = 0;
	logic phaseM = 1'h0;
	logic mode = SLD_CTRL_FOURFIELD_RST;
	logic run = 1'h0;
	logic prev;
	int pcnt = 0;
	int nv = 0;
	int n_fail = 0;
	int compares = 0;

	sld_status_led_driver #(.BLINK_HALF_CYC(HALF)) uut (
		.core_clk(core_clk), .rst_n(rst_n),
		.safetySwitchingOutputOn(st[0]), .deviceError(st[1]),
		.restartInterlockEnabled(st[2]), .restartInterlockReleased(st[3]),
		.protFieldOccupied(st[4]), .linkedSensorEnabled(st[5]),
		.warnFieldInterrupted(st[6]), .warnField2Interrupted(st[7]),
		.warnField3Interrupted(st[8]), .selfTestFail(st[9]),
		.internalCommError(st[10]), .identBlinkActive(st[11]),
		.safetyCommOn(st[12]), .safetyCommPassive(st[13]),
		.safetyCommActive(st[14]), .safetyConfigFail(st[15]),
		.safetyCommError(st[16]), .busInitialising(st[17]),
		.busDataExchange(st[18]), .topologyError(st[19]),
		.netConfigFail(st[20]), .noDataExchange(st[21]),
		.invalidData(st[22]), .busError(st[23]),
		.port1Link(st[24]), .port1Activity(st[25]),
		.port2Link(st[26]), .port2Activity(st[27]),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData),
		.safetyOutputIndicator(outs[2:0]), .restartIndicator(outs[5:3]),
		.warnFieldIndicator(outs[8:6]), .warnField3Indicator(outs[11:9]),
		.warnField2Indicator(outs[14:12]), .spareIndicator(outs[17:15]),
		.powerIndicator(outs[20:18]), .safetyCommIndicator(outs[23:21]),
		.networkIndicator(outs[26:24]), .port1LinkActivityIndicator(outs[29:27]),
		.port2LinkActivityIndicator(outs[32:30])
	);

	sld_led_panel panel (.ledCodes(outs), .litCount(litCount), .badCode(badCode));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// ------
	// Model
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [2:0] fl(input logic [2:0] col, input logic ph);
		return ph ? col : SLD_COL_OFF;
	endfunction

	function automatic logic [32:0] model(input logic [27:0] s, input logic ph, input logic m);
		logic [10:0][2:0] c;
		c = '0;
		c[0] = s[1] ? fl(SLD_COL_RED, ph) : (s[0] ? SLD_COL_GREEN : SLD_COL_RED);
		if (s[2] && !s[3]) begin
			c[1] = s[4] ? fl(SLD_COL_YELLOW, ph) : (s[5] ? SLD_COL_YELLOW : SLD_COL_OFF);
		end
		c[2] = s[6] ? SLD_COL_BLUE : SLD_COL_OFF;
		c[3] = (m && s[8]) ? SLD_COL_BLUE : SLD_COL_OFF;
		c[4] = (m && s[7]) ? fl(SLD_COL_YELLOW, ph) : SLD_COL_OFF;
		c[6] = (s[9] || s[10]) ? SLD_COL_RED :
			s[11] ? fl(SLD_COL_GREEN, ph) : SLD_COL_GREEN;
		c[7] = s[16] ? SLD_COL_RED : s[15] ? fl(SLD_COL_RED, ph) :
			(s[13] || s[11]) ? fl(SLD_COL_GREEN, ph) :
			(s[14] && s[12]) ? SLD_COL_GREEN : SLD_COL_OFF;
		c[8] = s[23] ? SLD_COL_RED :
			(s[20] || s[21] || s[22]) ? fl(SLD_COL_RED, ph) :
			s[19] ? fl(SLD_COL_ORANGE, ph) :
			(s[17] || s[11]) ? fl(SLD_COL_GREEN, ph) :
			s[18] ? SLD_COL_GREEN : SLD_COL_OFF;
		for (int i = 0; i < 2; i++) begin
			c[9+i] = !s[24+2*i] ? SLD_COL_OFF : !s[25+2*i] ? SLD_COL_GREEN :
				(ph ? SLD_COL_GREEN : SLD_COL_ORANGE);
		end
		return c;
	endfunction

	task automatic advance();
		if (pcnt == HALF) begin
			phaseM = !phaseM;
			pcnt = 1;
		end else begin
			pcnt++;
		end
	endtask

	// ------
	// Checks
	// ------
	task automatic cmpInd(input logic [2:0] got, input logic [2:0] want);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic cmpReg(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic results();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(negedge core_clk) begin
		if (run) begin
			if (nv > 0) begin
				lit = 0;
				for (int i = 0; i < 11; i++) begin
					cmpInd(outs[3*i+:3], expC[3*i+:3]);
					if (expC[3*i+:3] != SLD_COL_OFF) lit++;
				end
				cmpInd({2'h0, badCode}, 3'h0);
				cmpReg({28'h0, litCount}, 32'(lit));
			end
			// Expected read data wait one cycle in the queue
			if (expQ.size() > 0) begin
				expR = expQ.pop_front();
				if (nv > 1) cmpReg(regRdData, expR);
			end
			expR = SLD_RD_ZERO;
			if (regRd) begin
				case (regAddr)
					SLD_REG_CTRL: expR[0] = mode;
					SLD_REG_STAT0: expR[23:0] = expC[23:0];
					SLD_REG_STAT1: expR[8:0] = expC[32:24];
					SLD_REG_PHASE: expR[0] = phaseM;
					default: expR = SLD_RD_ZERO;
				endcase
			end
			expQ.push_back(expR);
			expC = model(st, phaseM, mode);
			if (regWr && regAddr == SLD_REG_CTRL) mode = regWrData[SLD_CTRL_FOURFIELD_BIT];
			advance();
			nv++;
		end
	end

	// ------
	// Stimulus
	// ------
	initial begin
		repeat (4) @(posedge core_clk);
		cmpReg({28'h0, litCount}, 32'h0);
		rst_n <= 1'h1;
		@(posedge core_clk);
		regAddr <= SLD_REG_PHASE;
		regRd <= 1'h1;
		@(posedge core_clk);
		@(negedge core_clk);
		prev = regRdData[0];
		// Align the model to the first phase edge seen through back-to-back reads
		for (int i = 0; i < 20 && pcnt == 0; i++) begin
			@(negedge core_clk);
			if (regRdData[0] !== prev) begin
				phaseM = !prev;
				pcnt = 2;
			end
		end
		if (pcnt == 0) begin
			n_fail++;
			results();
		end
		advance();
		@(posedge core_clk);
		run <= 1'h1;
		repeat (4000) begin
			r = lfsr(r);
			st <= r[27:0] & (r[31:4] | MASK);
			regWr <= (r[29:28] == 2'h1);
			regRd <= (r[29:28] == 2'h2);
			regAddr <= (r[30] && r[31]) ? r[15:8] : {4'h0, r[5:4], 2'h0};
			regWrData <= r;
			@(posedge core_clk);
		end
		results();
	end
endmodule

`default_nettype wire
